// *** common/fsq_pkg.sv ***
// Package of the flash sequencer host: pin bundle, commands, ops, offsets.
// Assumes one 20 MHz clock and a parallel NOR flash with clockless pins.
package fsq_pkg;
	localparam int FL_AW = 24;
	localparam int FL_DW = 16;
	localparam int WB_AW = 5;
	localparam int TW    = 8;

	// Software register byte offsets
	localparam logic [WB_AW-1:0] R_CTRL = 5'h00;
	localparam logic [WB_AW-1:0] R_ADDR = 5'h04;
	localparam logic [WB_AW-1:0] R_WDAT = 5'h08;
	localparam logic [WB_AW-1:0] R_STAT = 5'h0c;
	localparam logic [WB_AW-1:0] R_RDAT = 5'h10;

	// Control fields
	localparam int CT_RP = 8;

	// Status word fields
	localparam int ST_PULS = 5;
	localparam int ST_MODE = 6;
	localparam int ST_SR   = 8;

	// Flash command codes
	localparam logic [7:0] C_PROG     = 8'h40;
	localparam logic [7:0] C_PROG_ALT = 8'h10;
	localparam logic [7:0] C_CLR      = 8'h50;
	localparam logic [7:0] C_ARR      = 8'hff;
	localparam logic [7:0] C_CONF     = 8'hb8;
	localparam logic [7:0] CONF_MASK  = 8'h03;
	localparam logic [1:0] MODE_LEVEL = 2'b00;

	// Flash status bit positions
	localparam int SB_RDY = 7;
	localparam int SB_PE  = 4;
	localparam int SB_PS  = 2;

	// Software operations
	localparam logic [3:0] OP_NONE     = 4'h0;
	localparam logic [3:0] OP_PROG     = 4'h1;
	localparam logic [3:0] OP_SUSP     = 4'h2;
	localparam logic [3:0] OP_RES      = 4'h3;
	localparam logic [3:0] OP_CLR      = 4'h4;
	localparam logic [3:0] OP_ARR      = 4'h5;
	localparam logic [3:0] OP_CONF     = 4'h6;
	localparam logic [3:0] OP_POLL     = 4'h7;
	localparam logic [3:0] OP_READ     = 4'h8;
	localparam logic [3:0] OP_PROG_ALT = 4'h9;

	// Pin timing in ns
	localparam int T_CLK_NS = 50;
	localparam int T_WP_NS  = 100;
	localparam int T_WH_NS  = 50;
	localparam int T_RD_NS  = 150;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_WCMD = 3'b001,
		S_WDAT = 3'b010,
		S_RSTS = 3'b011,
		S_EVAL = 3'b100,
		S_WCLR = 3'b101,
		S_RARR = 3'b110
	} fsq_state_e;

	typedef struct packed {
		logic [FL_AW-1:0] addr;
		logic [FL_DW-1:0] dq;
		logic             dq_oe;
		logic             ce_n;
		logic             oe_n;
		logic             we_n;
		logic             rp_n;
	} fsq_pins_s;

	localparam fsq_pins_s PINS_RST = '{addr: '0, dq: '0, dq_oe: 1'b0, ce_n: 1'b1,
		oe_n: 1'b1, we_n: 1'b1, rp_n: 1'b1};
endpackage

// *** verilog/fsq_host.sv ***
// Host sequencer for a parallel NOR flash, run from Wishbone registers.
// Assumes the flash pins are wired to o_fl and i_fl_*, and software polls.
//
// Summary of operation
// [RULE1] Program is setup code 40H or 10H, then address and data write.
// [RULE2] After the program pair, reads return status until a new command.
// [RULE3] Completion shows on the status pin and on the ready flag.
// [RULE4] Verify reports only ones that failed to become zeros.
// [RULE5] After completion check program error; clear status when set.
// [RULE6] Decoder stays in status-read state after a program.
// [RULE7] Program at low program voltage sets program and voltage errors.
// [RULE8] Program to a locked block sets lock and program errors.
// [RULE9] Suspend during a program halts it; reads keep returning status.
// [RULE10] Suspended: ready and suspended flags set, level pin high.
// [RULE11] While suspended only reads, clear and resume are valid.
// [RULE12] Resume continues, clears suspended and ready, pin goes low.
// [RULE13] Set read configuration is ignored; array reads stay page mode.
// [RULE14] Status and identifier reads are single reads, never page reads.
// [RULE15] Read configuration: bit 16 read mode, bits 15..1 written zero.
// [RULE16] Pin configuration lasts until reconfigured or reset pin low.
// [RULE17] Level mode: pin low while busy, high when ready or suspended.
// [RULE18] Configure is B8h then a code with upper six bits zero.
// [RULE19] Pulse modes pulse the pin low on completion, about 250 ns.
// [RULE20] Configure only when neither busy nor suspended; check ready.
// [RULE21] An invalid configuration code sets program and erase errors.
// [RULE22] Clear status 50H clears error flags; valid when idle or suspended.
// [RULE23] Read array FFH returns to array reads, ending status reads.
// [RULE24] Suspend or resume with nothing to act on changes nothing.
`timescale 1ns/1ps

module fsq_host import fsq_pkg::*; #(
	parameter int         P_WP_NS    = T_WP_NS,
	parameter int         P_WH_NS    = T_WH_NS,
	parameter int         P_RD_NS    = T_RD_NS,
	parameter logic [7:0] P_CMD_SUSP = 8'hb0,
	parameter logic [7:0] P_CMD_RES  = 8'hd0,
	parameter logic [7:0] P_CMD_RSTS = 8'h70
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_nrst,
	input  wire logic             i_wb_cyc,
	input  wire logic             i_wb_stb,
	input  wire logic             i_wb_we,
	input  wire logic [WB_AW-1:0] i_wb_adr,
	input  wire logic [31:0]      i_wb_dat,
	input  wire logic [3:0]       i_wb_sel,
	output logic      [31:0]      o_wb_dat,
	output logic                  o_wb_ack,
	output fsq_pins_s             o_fl,
	input  wire logic [FL_DW-1:0] i_fl_dq,
	input  wire logic             i_fl_sts
);
	localparam int WP_CYC = (P_WP_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int WH_CYC = (P_WH_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int RD_CYC = (P_RD_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam logic [TW-1:0] WR_TOT = TW'(WP_CYC + WH_CYC - 1);
	localparam logic [TW-1:0] WH_TOT = TW'(WH_CYC);
	// Read adds two cycles of input sync
	localparam logic [TW-1:0] RD_TOT = TW'(RD_CYC + 2);

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_nrst);

	fsq_state_e       st;
	fsq_state_e       nst;
	logic [TW-1:0]    tmr;
	logic [TW-1:0]    next_tmr;
	logic [3:0]       cur_op;
	logic [31:0]      adr_reg;
	logic [31:0]      wdat;
	logic [FL_DW-1:0] rdat;
	logic [7:0]       sr;
	logic             prog_act;
	logic             susp;
	logic             sr_mode;
	logic             chk_ok;
	logic             refused;
	logic             rp_assert;
	logic [1:0]       sts_mode;
	logic             pulse_seen;
	logic [FL_DW-1:0] dq_m;
	logic [FL_DW-1:0] dq_s;
	logic             sts_m;
	logic             sts_s;
	logic             sts_d;

	////////////////////////////////////////////////////////////////////////
	// Decode functions

	function automatic logic is_prog(input logic [3:0] op);
		return op == OP_PROG || op == OP_PROG_ALT;
	endfunction

	function automatic logic is_wr(input fsq_state_e s);
		return s == S_WCMD || s == S_WDAT || s == S_WCLR;
	endfunction

	function automatic logic is_rd(input fsq_state_e s);
		return s == S_RSTS || s == S_RARR;
	endfunction

	function automatic logic [7:0] op_code(input logic [3:0] op);
		case (op)
			OP_PROG:     op_code = C_PROG;
			OP_PROG_ALT: op_code = C_PROG_ALT;
			OP_SUSP:     op_code = P_CMD_SUSP;
			OP_RES:      op_code = P_CMD_RES;
			OP_CLR:      op_code = C_CLR;
			OP_ARR:      op_code = C_ARR;
			default:     op_code = P_CMD_RSTS;
		endcase
	endfunction

	// Ops legal in the host's view of the flash; unknown ops are refused
	function automatic logic op_legal(input logic [3:0] op, input logic act, input logic sus);
		case (op)
			OP_PROG, OP_PROG_ALT: op_legal = !act; // RULE11
			OP_SUSP:              op_legal = act && !sus; // RULE9
			OP_RES:               op_legal = sus;
			OP_CLR:               op_legal = !act || sus; // RULE22
			OP_ARR, OP_READ:      op_legal = !act || sus; // RULE11
			OP_CONF:              op_legal = !act; // RULE20
			OP_POLL:              op_legal = 1'b1;
			default:              op_legal = 1'b0; // RULE13 RULE15
		endcase
	endfunction

	function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] sel);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus decode and sequencer selection

	wire              wb_req   = i_wb_cyc && i_wb_stb && !o_wb_ack;
	wire              wb_wr    = wb_req && i_wb_we;
	wire              wr_ctrl  = wb_wr && i_wb_adr == R_CTRL && i_wb_sel[0];
	wire              wr_rp    = wb_wr && i_wb_adr == R_CTRL && i_wb_sel[1];
	wire [3:0]        wop      = i_wb_dat[3:0];
	wire              go       = wr_ctrl && st == S_IDLE && op_legal(wop, prog_act, susp);
	wire              tdone    = tmr == '0;
	wire              wr_end   = tdone && is_wr(st);
	wire              rdy      = sr[SB_RDY];
	wire              conf_ok  = rdy && !sr[SB_PS]; // RULE20
	wire              pls_clr  = wb_wr && i_wb_adr == R_STAT && i_wb_sel[0] && i_wb_dat[ST_PULS];
	wire              sts_rise = sts_s && !sts_d;
	wire              is_chk   = cur_op == OP_CONF || cur_op == OP_POLL;
	// After a program the flash already returns status, so skip read-status
	wire fsq_state_e  first_st = wop == OP_READ ? S_RARR :
		((wop == OP_POLL || wop == OP_CONF) && sr_mode) ? S_RSTS : S_WCMD; // RULE6
	wire fsq_state_e  wcmd_nxt = (is_prog(cur_op) || (cur_op == OP_CONF && chk_ok)) ? S_WDAT :
		is_chk ? S_RSTS : S_IDLE; // RULE1
	wire fsq_state_e  eval_nxt = (cur_op == OP_CONF && conf_ok) ? S_WCMD :
		(rdy && sr[SB_PE]) ? S_WCLR : S_IDLE; // RULE5
	wire [3:0]        op_now   = st == S_IDLE ? wop : cur_op;
	wire [FL_DW-1:0]  dat2     = cur_op == OP_CONF ? FL_DW'(wdat[7:0] & CONF_MASK) :
		wdat[FL_DW-1:0]; // RULE18
	wire [FL_DW-1:0]  next_dq  = nst == S_WDAT ? dat2 : nst == S_WCLR ? FL_DW'(C_CLR) :
		(st == S_EVAL || (st == S_WCMD && chk_ok)) ? FL_DW'(C_CONF) : FL_DW'(op_code(op_now)); // RULE23
	wire [TW-1:0]     ld       = is_wr(nst) ? WR_TOT : is_rd(nst) ? RD_TOT : '0;
	wire [31:0]       stat_w   = {16'h0000, sr, sts_mode, pulse_seen, sts_s, refused, susp,
		prog_act, st != S_IDLE};
	wire [31:0]       rd_word  = i_wb_adr == R_CTRL ? {23'h0, rp_assert, 4'h0, cur_op} :
		i_wb_adr == R_ADDR ? adr_reg : i_wb_adr == R_WDAT ? wdat :
		i_wb_adr == R_STAT ? stat_w : i_wb_adr == R_RDAT ? 32'(rdat) : 32'h0;

	// Timer reloads on state entry, otherwise counts down to zero and holds there
	assign next_tmr = nst != st ? ld : tdone ? tmr : tmr - 1'b1;

	// Next state
	always_comb begin
		nst = st;
		case (st)
			S_IDLE:                 if (go) nst = first_st;
			S_WCMD:                 if (tdone) nst = wcmd_nxt;
			S_WDAT, S_WCLR, S_RARR: if (tdone) nst = S_IDLE;
			S_RSTS:                 if (tdone) nst = S_EVAL; // RULE14
			S_EVAL:                 nst = eval_nxt;
			default:                nst = S_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer registers

	// State, timer and op capture
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st     <= S_IDLE;
			tmr    <= '0;
			cur_op <= OP_NONE;
			chk_ok <= 1'b0;
		end else begin
			st     <= nst;
			tmr    <= next_tmr;
			cur_op <= go ? wop : cur_op;
			chk_ok <= st == S_EVAL ? conf_ok : (st == S_IDLE ? 1'b0 : chk_ok);
		end
	end

	// Host view of the flash state
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prog_act <= 1'b0;
			susp     <= 1'b0;
			sr_mode  <= 1'b0;
			sts_mode <= MODE_LEVEL;
		end else if (rp_assert) begin
			prog_act <= 1'b0;
			susp     <= 1'b0;
			sr_mode  <= 1'b0;
			sts_mode <= MODE_LEVEL; // RULE16
		end else begin
			if (st == S_WDAT && tdone && is_prog(cur_op))
				prog_act <= 1'b1; // RULE2
			else if (st == S_EVAL && cur_op == OP_POLL && conf_ok)
				prog_act <= 1'b0; // RULE3
			if (st == S_EVAL && cur_op == OP_POLL && prog_act && rdy && sr[SB_PS])
				susp <= 1'b1; // RULE10
			else if (wr_end && st == S_WCMD && cur_op == OP_RES)
				susp <= 1'b0; // RULE12
			if (wr_end)
				sr_mode <= !(st == S_WCMD && cur_op == OP_ARR); // RULE23
			if (st == S_WDAT && tdone && cur_op == OP_CONF)
				sts_mode <= dat2[1:0]; // RULE18
		end
	end

	// Sampled read data
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sr   <= 8'h00;
			rdat <= '0;
		end else begin
			sr   <= (st == S_RSTS && tdone) ? dq_s[7:0] : sr; // RULE3
			rdat <= (st == S_RARR && tdone) ? dq_s : rdat;
		end
	end

	// Flash pins, registered from the next state
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_fl <= PINS_RST;
		end else begin
			o_fl.addr  <= go ? adr_reg[FL_AW-1:0] : o_fl.addr;
			o_fl.dq    <= next_dq;
			o_fl.dq_oe <= is_wr(nst);
			o_fl.ce_n  <= !(is_wr(nst) || is_rd(nst));
			o_fl.oe_n  <= !is_rd(nst);
			o_fl.we_n  <= !(is_wr(nst) && next_tmr >= WH_TOT); // RULE1
			o_fl.rp_n  <= !rp_assert;
		end
	end

	// Pin input synchronisers
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			dq_m  <= '0;
			dq_s  <= '0;
			sts_m <= 1'b1;
			sts_s <= 1'b1;
			sts_d <= 1'b1;
		end else begin
			dq_m  <= i_fl_dq;
			dq_s  <= dq_m;
			sts_m <= i_fl_sts;
			sts_s <= sts_m;
			sts_d <= sts_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wishbone slave registers

	// Software registers; a completion pulse wins over its clear
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			adr_reg    <= 32'h0;
			wdat       <= 32'h0;
			rp_assert  <= 1'b0;
			refused    <= 1'b0;
			pulse_seen <= 1'b0;
		end else begin
			if (wb_wr && i_wb_adr == R_ADDR)
				adr_reg <= wmask(adr_reg, i_wb_dat, i_wb_sel);
			if (wb_wr && i_wb_adr == R_WDAT)
				wdat <= wmask(wdat, i_wb_dat, i_wb_sel);
			if (wr_rp)
				rp_assert <= i_wb_dat[CT_RP];
			if (wr_ctrl && wop != OP_NONE)
				refused <= !go; // RULE24
			else if (st == S_EVAL && cur_op == OP_CONF && !conf_ok)
				refused <= 1'b1; // RULE20
			if (sts_rise && sts_mode != MODE_LEVEL)
				pulse_seen <= 1'b1; // RULE19
			else if (pls_clr)
				pulse_seen <= 1'b0;
		end
	end

	// Ack one cycle after the strobe, read data registered with it
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
		end else begin
			o_wb_ack <= wb_req;
			o_wb_dat <= wb_req ? rd_word : 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	a_prog_setup_code: assert property ((st == S_WCMD && is_prog(cur_op)) |-> // RULE1
		(o_fl.dq[7:0] == C_PROG || o_fl.dq[7:0] == C_PROG_ALT)) else $error("bad setup code");
	a_prog_then_data: assert property ((st == S_WCMD && is_prog(cur_op) && tdone) |=> // RULE1
		(st == S_WDAT && o_fl.dq == wdat[FL_DW-1:0])) else $error("data write missing");
	a_prog_marks_act: assert property ((st == S_WDAT && is_prog(cur_op) && tdone) |=> // RULE2
		prog_act) else $error("program not tracked");
	a_ready_ends_prog: assert property ((st == S_EVAL && cur_op == OP_POLL && conf_ok) |=> // RULE3
		!prog_act) else $error("ready not seen");
	a_err_auto_clear: assert property ((st == S_EVAL && cur_op != OP_CONF && rdy && sr[SB_PE]) // RULE5
		|=> (st == S_WCLR && o_fl.dq[7:0] == C_CLR)) else $error("error not cleared");
	a_no_prog_susp: assert property ((st == S_WCMD && is_prog(cur_op)) |-> !susp) // RULE11
		else $error("program while suspended");
	a_resume_clears: assert property ((st == S_WCMD && cur_op == OP_RES && tdone) |=> // RULE12
		!susp) else $error("resume kept suspend");
	a_rp_level_mode: assert property (!o_fl.rp_n |-> sts_mode == MODE_LEVEL) // RULE16
		else $error("mode kept in reset");
	a_conf_code_mask: assert property ((st == S_WDAT && cur_op == OP_CONF) |-> // RULE18
		o_fl.dq[FL_DW-1:2] == '0) else $error("config code unmasked");
	a_conf_gated: assert property ((st == S_WDAT && cur_op == OP_CONF) |-> // RULE20
		(conf_ok && !prog_act && !susp)) else $error("config while busy");
	a_clr_gated: assert property ((st == S_WCMD && cur_op == OP_CLR) |-> // RULE22
		(!prog_act || susp)) else $error("clear while running");
	a_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");

	c_prog_done: cover property ($fell(prog_act));
	c_suspended: cover property ($rose(susp));
	c_conf_write: cover property (st == S_WDAT && cur_op == OP_CONF && tdone);
	c_pulse_seen: cover property ($rose(pulse_seen));
endmodule

// *** test/fsq_flash_model.sv ***
// Behavioural parallel NOR flash for the host bench: commands, status, pin.
// Assumes writes latch on the rising write strobe while chip enable is low.
`timescale 1ns/1ps
module fsq_flash_model import fsq_pkg::*; #(
	parameter int P_PROG_TICKS = 60
) (
	input  wire logic [FL_AW-1:0] i_addr,
	input  wire logic [FL_DW-1:0] i_dq,
	input  wire logic             i_ce_n,
	input  wire logic             i_oe_n,
	input  wire logic             i_we_n,
	input  wire logic             i_rp_n,
	input  wire logic             i_program_enable_voltage_ok,
	input  wire logic             i_lock,
	output logic      [FL_DW-1:0] o_dq,
	output logic                  o_sts
);
	logic [15:0] mem [16];
	logic [15:0] held;
	logic [15:0] rd_val;
	logic [15:0] pd;
	logic [7:0]  sr;
	logic [3:0]  pa;
	logic [1:0]  mode;
	logic        busy, susp, sreq, in_sts, p_prog, p_conf, pulse_n, ready;
	int          left;
	////////////////////////////////////////////////////////////////////////////
	// Read path: status or array word; a released bus shows the inverse
	assign ready  = !busy || susp;
	assign rd_val = in_sts ? {8'h00, ready, sr[6:0]} : mem[i_addr[3:0]];
	assign o_dq   = (!i_ce_n && !i_oe_n) ? rd_val : held;
	assign o_sts  = (mode == 2'b00) ? ready : pulse_n;
	always @(posedge i_oe_n) held = ~rd_val;
	// Power-up and reset pin clear state and pin mode
	task automatic wipe();
		{busy, susp, sreq, in_sts, p_prog, p_conf} = 6'h00;
		{mode, sr, pulse_n} = 11'h001;
		held = 16'h0000;
	endtask
	initial begin
		for (int k = 0; k < 16; k++) mem[k] = 16'hffff;
		wipe();
	end
	always @(negedge i_rp_n) wipe();
	////////////////////////////////////////////////////////////////////////////
	// Command decoder on the rising write strobe
	always @(posedge i_we_n) begin
		if (!i_ce_n && i_rp_n) begin
			if (p_prog) begin
				p_prog = 1'b0;
				in_sts = 1'b1;
				if (!i_program_enable_voltage_ok) sr[4:3] = 2'b11;
				else if (i_lock) sr = sr | 8'h12;
				else begin
					busy = 1'b1;
					left = P_PROG_TICKS;
					pa = i_addr[3:0];
					pd = i_dq;
				end
			end else if (p_conf) begin
				p_conf = 1'b0;
				if (i_dq[7:2] != 6'h00) sr[5:4] = 2'b11;
				else mode = i_dq[1:0];
			end else begin
				case (i_dq[7:0])
					8'h40, 8'h10: p_prog = !busy;
					8'hb8: p_conf = !busy;
					8'h50: if (ready) sr = sr & 8'h04;
					8'hff: in_sts = 1'b0;
					8'h70: in_sts = 1'b1;
					8'hb0: sreq = busy && !susp;
					8'hd0: if (susp) {susp, sr[2], in_sts} = 3'b001;
					default: ;
				endcase
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Program timer; a suspend halts it at the next tick
	always begin
		#50;
		if (busy && sreq) {sreq, susp, sr[2]} = 3'b011;
		else if (busy && !susp) left = left - 1;
		if (busy && !susp && left == 0) begin
			busy = 1'b0;
			mem[pa] = mem[pa] & pd;
			if (mode[1]) begin
				pulse_n = 1'b0;
				pulse_n <= #250 1'b1;
			end
		end
	end
endmodule

// *** test/testbench.sv ***
// Testbench of the flash sequencer host: Wishbone tasks drive scripted ops.
// Assumes the behavioural flash model stands on the flash pins.
`timescale 1ns/1ps
module testbench import fsq_pkg::*; ;
	logic             clk, nrst, cyc, stb, we, ack, program_enable_voltage_ok, lock, sts;
	logic [3:0]       sel;
	logic [WB_AW-1:0] adr;
	logic [31:0]      wdat, rdat, wb_q;
	logic [FL_DW-1:0] m_dq;
	wire  [FL_DW-1:0] dq_w;
	fsq_pins_s        fl;
	int               n_fail, compares;
	// Data wire seen by both parties
	assign dq_w = fl.dq_oe ? fl.dq : m_dq;
	fsq_host fsq_host_i (.i_sys_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .o_fl(fl),
		.i_fl_dq(dq_w), .i_fl_sts(sts));
	fsq_flash_model fsq_flash_model_i (.i_addr(fl.addr), .i_dq(dq_w), .i_ce_n(fl.ce_n), .i_oe_n(fl.oe_n),
		.i_we_n(fl.we_n), .i_rp_n(fl.rp_n), .i_program_enable_voltage_ok(program_enable_voltage_ok), .i_lock(lock), .o_dq(m_dq), .o_sts(sts));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////
	// Verdict, compare and bus tasks
	task automatic give_verdict();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wb(input logic [WB_AW-1:0] a, input logic [31:0] d, input logic w);
		int t;
		t = 0;
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
		@(posedge clk);
		while (ack !== 1'b1 && t < 50) begin
			@(posedge clk);
			t++;
		end
		wb_q = rdat;
		if (t == 50) n_fail++;
		{cyc, stb} <= 2'b00;
		@(posedge clk);
	endtask
	// Issue an op and wait until busy drops; wb_q keeps the last status
	task automatic op(input logic [3:0] o);
		int t;
		t = 0;
		wb(R_CTRL, {28'h0, o}, 1'b1);
		do begin
			wb(R_STAT, 32'h0, 1'b0);
			t++;
		end while (wb_q[0] !== 1'b0 && t < 100);
		if (t == 100) n_fail++;
	endtask
	task automatic poll_until(input int b);
		int t;
		t = 0;
		do begin
			op(OP_POLL);
			t++;
		end while (wb_q[b] !== 1'b1 && t < 200);
		if (t == 200) n_fail++;
	endtask
	task automatic prog(input logic [3:0] o, input logic [23:0] a, input logic [15:0] d);
		wb(R_ADDR, {8'h00, a}, 1'b1);
		wb(R_WDAT, {16'h0, d}, 1'b1);
		op(o);
	endtask
	task automatic arr(input logic [23:0] a, input logic [15:0] e);
		wb(R_ADDR, {8'h00, a}, 1'b1);
		op(OP_ARR);
		op(OP_READ);
		wb(R_RDAT, 32'h0, 1'b0);
		chk("rdat", wb_q, {16'h0, e});
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Watchdog against a hang
	initial begin
		#1000000;
		n_fail++;
		give_verdict();
	end
	// Main sequence
	initial begin
		{cyc, stb, we, nrst, lock, program_enable_voltage_ok} = 6'h01;
		{sel, adr, wdat} = '0;
		{n_fail, compares} = 64'h0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		// Reset state and an unmapped place
		wb(R_STAT, 32'h0, 1'b0);
		chk("stat_rst", {26'h0, wb_q[7:6], wb_q[3:0]}, 32'h0);
		wb(5'h14, 32'h0, 1'b0);
		chk("unmapped", wb_q, 32'h0);
		// Program, then a second program that may not turn a 0 into 1
		prog(OP_PROG, 24'h3, 16'h12f0);
		wb(R_STAT, 32'h0, 1'b0);
		chk("sts_busy", 32'(wb_q[4]), 32'h0);
		chk("prog_act", 32'(wb_q[1]), 32'h1);
		poll_until(ST_SR + SB_RDY);
		chk("sr_done", 32'(wb_q[15:8]), 32'h80);
		arr(24'h3, 16'h12f0);
		prog(OP_PROG_ALT, 24'h3, 16'hffff);
		poll_until(ST_SR + SB_RDY);
		chk("sr_nofail", 32'(wb_q[15:8]), 32'h80);
		arr(24'h3, 16'h12f0);
		// Suspend mid-program, read elsewhere, resume
		prog(OP_PROG, 24'h5, 16'h00aa);
		op(OP_PROG);
		chk("refuse_busy", 32'(wb_q[3]), 32'h1);
		op(OP_SUSP);
		poll_until(SB_PS);
		chk("sr_susp", 32'(wb_q[15:8]), 32'h84);
		chk("sts_susp", 32'(wb_q[4]), 32'h1);
		arr(24'h3, 16'h12f0);
		op(OP_RES);
		chk("res_ps", 32'(wb_q[2]), 32'h0);
		chk("res_sts", 32'(wb_q[4]), 32'h0);
		poll_until(ST_SR + SB_RDY);
		arr(24'h5, 16'h00aa);
		// Resume with nothing suspended
		op(OP_RES);
		chk("res_idle", 32'(wb_q[3]), 32'h1);
		op(OP_POLL);
		chk("sr_idle", 32'(wb_q[15:8]), 32'h80);
		// Low program voltage, then a locked block
		for (int i = 0; i < 2; i++) begin
			program_enable_voltage_ok <= i[0];
			lock <= i[0];
			prog(OP_PROG, 24'h6, 16'h0000);
			poll_until(ST_SR + SB_RDY);
			chk("sr_err", 32'(wb_q[15:8]), (i == 1) ? 32'h92 : 32'h98);
			program_enable_voltage_ok <= 1'b1;
			lock <= 1'b0;
			op(OP_POLL);
			chk("sr_clr", 32'(wb_q[15:8]), 32'h80);
		end
		// Each pulse code, a program, and whether a pulse came
		for (int c = 1; c < 4; c++) begin
			wb(R_WDAT, 32'(c), 1'b1);
			op(OP_CONF);
			chk("sts_mode", 32'(wb_q[7:6]), 32'(c));
			wb(R_STAT, 32'h20, 1'b1);
			prog(OP_PROG, 24'h7, 16'h0000);
			poll_until(ST_SR + SB_RDY);
			chk("pulse", 32'(wb_q[5]), 32'(c[1]));
		end
		// Reset pin brings level mode back
		wb(R_CTRL, 32'h100, 1'b1);
		wb(R_CTRL, 32'h0, 1'b1);
		prog(OP_PROG, 24'h8, 16'h0000);
		wb(R_STAT, 32'h0, 1'b0);
		chk("sts_rp", 32'(wb_q[4]), 32'h0);
		poll_until(ST_SR + SB_RDY);
		wb(R_WDAT, 32'h0, 1'b1);
		op(OP_CONF);
		chk("mode_lvl", 32'(wb_q[7:6]), 32'h0);
		give_verdict();
	end
endmodule
